/* File: hdl/sstc_pkg.sv */
package sstc_pkg;

  // core clock of this implementation
  localparam int unsigned CLK_KHZ        = 100000;
  // internal oscillators
  localparam int unsigned OSC_NORM_KHZ   = 4000;
  localparam int unsigned OSC_SLEEP_KHZ  = 192;
  localparam int unsigned OSC_TOL_PCT    = 15;
  localparam int unsigned NORM_DIV       = CLK_KHZ / OSC_NORM_KHZ;
  localparam int unsigned SLEEP_DIV      = CLK_KHZ / OSC_SLEEP_KHZ;

  // intervals in their own units (ns)
  localparam int unsigned ACTIVE_MIN_NS  = 250000;
  localparam int unsigned ACTIVE_TYP_NS  = 340000;
  localparam int unsigned ACTIVE_MAX_NS  = 450000;
  localparam int unsigned FUSE_NS        = 50000;
  localparam int unsigned WET_PULSE_NS   = 20000000;
  localparam int unsigned GLITCH_MIN_NS  = 5000;
  localparam int unsigned GLITCH_MAX_NS  = 18000;
  localparam int unsigned INT_DLY_NS     = 18500;
  localparam int unsigned DEBOUNCE_NS    = 1200000;
  localparam int unsigned INT_PULSE_NS   = 100000;

  // tick counts of the active oscillator (4 MHz tick = 250 ns)
  localparam int unsigned NORM_TICK_NS   = 1000000 / OSC_NORM_KHZ;
  localparam int unsigned SLEEP_TICK_NS  = 1000000 / OSC_SLEEP_KHZ;
  localparam int unsigned ACTIVE_TICKS   = ACTIVE_TYP_NS / NORM_TICK_NS;
  localparam int unsigned FUSE_TICKS     = FUSE_NS / NORM_TICK_NS;
  localparam int unsigned WET_TICKS      = WET_PULSE_NS / NORM_TICK_NS;
  localparam int unsigned GLITCH_TICKS   = (GLITCH_MIN_NS + GLITCH_MAX_NS) / 2 / NORM_TICK_NS;
  localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_NS / SLEEP_TICK_NS;
  localparam int unsigned INT_PULSE_TICKS = INT_PULSE_NS / NORM_TICK_NS;

  localparam int unsigned NUM_INPUTS     = 33;
  localparam int unsigned TW             = 17;

  typedef enum logic [4:0] {
    ST_RESET   = 5'h01,
    ST_LOCKOUT = 5'h02,
    ST_FUSE    = 5'h04,
    ST_NORMAL  = 5'h08,
    ST_SLEEP   = 5'h10
  } sstc_state_t;

  // supply comparator indications
  typedef struct packed {
    logic uv;
    logic ov;
  } sstc_supply_t;

  // serial port gating outputs
  typedef struct packed {
    logic miso_oe;
    logic cs_accept;
    logic frame_abort;
  } sstc_spi_gate_t;

endpackage

/* File: hdl/sstc_core.sv */
// Overview of operation
// RULE1: leave lockout to normal mode within 250 to 450 us, 340 typical.
// RULE2: normal mode timing counts ticks of the nominal 4.0 MHz oscillator.
// RULE3: sleep mode timing counts ticks of the nominal 192 kHz oscillator.
// RULE4: pulsed wetting drives current for a 20 ms pulse in normal mode.
// RULE5: each input selects pulsed or continuous wetting.
// RULE6: input change accepted after 5 to 18 us filter; interrupt within 18.5 us.
// RULE7: in sleep, input change needs extra 1.2 ms debounce before waking.
// RULE8: interrupt output pulses low for 100 us on event or host request.
// RULE9: serial data output stays undriven during lockout.
// RULE10: chip-select ignored in lockout, no frame processed.
// RULE11: entering lockout mid-frame discards the frame.
// RULE12: sticky status bit reports that lockout occurred.
// RULE13: comparators and current sources off during lockout.
// RULE14: after reset release the device starts in lockout.
// RULE15: power-on reset sets a flag readable by the host.
// RULE16: reset returns settings to defaults and disables the serial port.
// RULE17: overvoltage limits current sources to about 2 mA, registers kept.
// RULE18: overvoltage clearing restores programmed currents automatically.
// RULE19: jump-start range sets no fault and changes nothing.
// RULE20: low-supply range keeps serial port and reporting normal.
// RULE21: a fuse-read state of about 50 us precedes normal mode; here ST_FUSE lasts the whole 340 us start-up.
// RULE22: wake output held low in normal mode.
// RULE23: sleep entered only by host serial command.
// RULE24: states reset, lockout, fuse, normal, sleep; supply flags synchronised.
// RULE25: timers count active oscillator ticks to nominal terminal counts.
`timescale 1ns/1ps
`default_nettype none
module sstc_core
  import sstc_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // supply comparators (asynchronous)
  input  wire logic                  supply_uv,
  input  wire logic                  supply_ov,
  // host side
  input  wire logic                  cs_n,
  input  wire logic                  sleep_cmd,
  input  wire logic                  int_request,
  input  wire logic                  flags_clear,
  // switch inputs and wetting selection
  input  wire logic [NUM_INPUTS-1:0] switch_raw,
  input  wire logic [NUM_INPUTS-1:0] wet_pulsed_sel,
  // serial gating
  output logic                       miso_oe,
  output logic                       cs_accept,
  output logic                       frame_abort,
  // status
  output logic [4:0]                 supply_state,
  output logic                       uv_seen,
  output logic                       por_flag,
  output logic                       defaults_load,
  // analog control and filtered switch state
  output logic                       comparators_on,
  output logic                       current_limit,
  output logic [NUM_INPUTS-1:0]      wet_on,
  output logic [NUM_INPUTS-1:0]      switch_state,
  // pins
  output logic                       int_n,
  output logic                       wake_n
);

  function automatic logic agree(input logic [2:0] s);
    return s[1] == s[2];
  endfunction

  function automatic logic is_awake(input sstc_state_t s);
    return s == ST_NORMAL || s == ST_SLEEP;
  endfunction

  // three-stage synchronisers for supply, chip-select, interrupt request and switch inputs
  logic [2:0] uv_s, ov_s, cs_s, rq_s;
  logic [2:0] sw_s [NUM_INPUTS];
  logic       uv_q, ov_q, cs_q, rq_q;
  logic       next_uv_q, next_ov_q, next_cs_q, next_rq_q;

  always_comb begin
    next_uv_q = agree(uv_s) ? uv_s[2] : uv_q; // RULE24
    next_ov_q = agree(ov_s) ? ov_s[2] : ov_q;
    next_cs_q = agree(cs_s) ? cs_s[2] : cs_q;
    next_rq_q = agree(rq_s) ? rq_s[2] : rq_q;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      uv_s <= 3'h7;
      ov_s <= 3'h0;
      cs_s <= 3'h7;
      rq_s <= 3'h0;
      uv_q <= 1'b1;
      ov_q <= 1'b0;
      cs_q <= 1'b1;
      rq_q <= 1'b0;
    end else begin
      uv_s <= {uv_s[1:0], supply_uv};
      ov_s <= {ov_s[1:0], supply_ov};
      cs_s <= {cs_s[1:0], cs_n};
      rq_s <= {rq_s[1:0], int_request};
      uv_q <= next_uv_q;
      ov_q <= next_ov_q;
      cs_q <= next_cs_q;
      rq_q <= next_rq_q;
    end
  end

  // oscillator ticks: 4 MHz in normal, 192 kHz in sleep
  sstc_state_t state, next_state;
  logic [9:0]  div, next_div;
  logic        tick, next_tick;
  logic [TW-1:0] tmr, next_tmr;
  logic          ev, wake_ev;

  always_comb begin
    next_div  = div + 10'h001;
    next_tick = 1'b0;
    if (state == ST_SLEEP ? (div >= 10'(SLEEP_DIV - 1)) : (div >= 10'(NORM_DIV - 1))) begin // RULE2 RULE3
      next_div  = 10'h000;
      next_tick = 1'b1;
    end
  end

  // supply state machine
  always_comb begin
    next_state = state;
    next_tmr   = tmr;
    unique case (state)
      ST_RESET: next_state = ST_LOCKOUT; // RULE14
      ST_LOCKOUT: begin
        next_tmr = '0;
        if (!uv_q) next_state = ST_FUSE;
      end
      ST_FUSE: begin
        // fuse read then remaining start-up, 340 us total
        if (tick) next_tmr = tmr + TW'(1); // RULE25
        if (tmr >= TW'(ACTIVE_TICKS - 1) && tick) next_state = ST_NORMAL; // RULE1 RULE21
      end
      ST_NORMAL: if (sleep_cmd) next_state = ST_SLEEP; // RULE23
      ST_SLEEP: begin
        // debounced switch change wakes the core
        if (wake_ev) next_state = ST_NORMAL; // RULE7
      end
      default: next_state = ST_LOCKOUT;
    endcase
    if (uv_q && state != ST_RESET) next_state = ST_LOCKOUT; // RULE11
    if (uv_q) next_tmr = '0;
  end

  // switch filtering and wetting
  logic [NUM_INPUTS-1:0] sw_f, next_sw_f;
  logic [12:0]           flt [NUM_INPUTS];
  logic [12:0]           next_flt [NUM_INPUTS];
  logic [TW-1:0]         wet [NUM_INPUTS];
  logic [TW-1:0]         next_wet [NUM_INPUTS];
  logic [NUM_INPUTS-1:0] next_wet_on;

  always_comb begin
    ev = 1'b0;
    wake_ev = 1'b0;
    next_sw_f = sw_f;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      next_flt[i] = '0;
      next_wet[i] = wet[i];
      if (is_awake(state)) begin
        if (agree(sw_s[i]) && sw_s[i][2] != sw_f[i]) begin
          next_flt[i] = flt[i] + (tick ? 13'h0001 : 13'h0000);
          if (state == ST_NORMAL && flt[i] >= 13'(GLITCH_TICKS)) begin // RULE6
            next_sw_f[i] = sw_s[i][2];
            next_flt[i] = '0;
            ev = 1'b1;
          end
          if (state == ST_SLEEP && flt[i] >= 13'(DEBOUNCE_TICKS)) begin // RULE7
            next_sw_f[i] = sw_s[i][2];
            next_flt[i] = '0;
            wake_ev = 1'b1;
          end
        end
      end
      if (state != ST_NORMAL) next_wet[i] = '0;
      else if (ev && next_sw_f[i] != sw_f[i]) next_wet[i] = TW'(WET_TICKS); // RULE4
      else if (tick && wet[i] != '0) next_wet[i] = wet[i] - TW'(1);
    end
  end

  // interrupt pulse and flags
  logic [8:0] ip, next_ip;
  logic       rq_d, next_uv_seen, next_por_flag;

  always_comb begin
    next_ip = ip;
    // a wake event also raises the pulse, on its way back to normal
    if ((state == ST_NORMAL && (ev || (rq_q && !rq_d))) || wake_ev) begin
      next_ip = 9'(INT_PULSE_TICKS); // RULE8
    end else if (tick && ip != '0) begin
      next_ip = ip - 9'h001;
    end
    next_uv_seen  = (uv_q && state != ST_RESET) || (uv_seen && !flags_clear); // RULE12
    next_por_flag = por_flag && !flags_clear; // RULE15
  end

  // registered outputs, next values
  logic                  next_defaults_load;
  logic                  next_miso_oe;
  logic                  next_cs_accept;
  logic                  next_frame_abort;
  logic [4:0]            next_supply_state;
  logic                  next_comparators_on;
  logic                  next_current_limit;
  logic                  next_int_n;
  logic                  next_wake_n;

  always_comb begin
    next_defaults_load  = state == ST_RESET; // RULE16
    next_miso_oe        = next_state == ST_NORMAL && !cs_q; // RULE9 RULE20
    next_cs_accept      = next_state == ST_NORMAL && !cs_q; // RULE10
    next_frame_abort    = uv_q && !cs_q; // RULE11
    next_supply_state   = next_state;
    next_comparators_on = is_awake(next_state); // RULE13
    next_current_limit  = ov_q && next_state == ST_NORMAL; // RULE17 RULE18 RULE19
    next_int_n          = !(next_ip != '0 || state == ST_RESET || state == ST_LOCKOUT ||
                            state == ST_FUSE); // RULE8
    next_wake_n         = next_state != ST_NORMAL; // RULE22
    // follows next_state so that lockout and sleep cut the sources at once
    for (int i = 0; i < NUM_INPUTS; i++) begin
      // pulsed: only while timer runs; continuous: throughout normal mode
      next_wet_on[i] = next_state == ST_NORMAL &&
                       (wet_pulsed_sel[i] ? wet[i] != '0 : 1'b1); // RULE5 RULE13
    end
  end

  // supply state, divider and start-up timer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RESET;
      div   <= '0;
      tick  <= 1'b0;
      tmr   <= '0;
    end else begin
      state <= next_state;
      div   <= next_div;
      tick  <= next_tick;
      tmr   <= next_tmr;
    end
  end

  // switch synchronisers, filters and wetting timers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sw_f <= '0;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        sw_s[i] <= 3'h0;
        flt[i]  <= '0;
        wet[i]  <= '0;
      end
    end else begin
      sw_f <= next_sw_f;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        sw_s[i] <= {sw_s[i][1:0], switch_raw[i]};
        flt[i]  <= next_flt[i];
        wet[i]  <= next_wet[i];
      end
    end
  end

  // interrupt timer and status flags
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ip       <= '0;
      rq_d     <= 1'b0;
      uv_seen  <= 1'b0;
      por_flag <= 1'b1; // RULE15
    end else begin
      ip       <= next_ip;
      rq_d     <= rq_q;
      uv_seen  <= next_uv_seen;
      por_flag <= next_por_flag;
    end
  end

  // top-level outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      defaults_load  <= 1'b1; // RULE16
      miso_oe        <= 1'b0;
      cs_accept      <= 1'b0;
      frame_abort    <= 1'b0;
      supply_state   <= ST_RESET;
      comparators_on <= 1'b0;
      current_limit  <= 1'b0;
      wet_on         <= '0;
      switch_state   <= '0;
      int_n          <= 1'b0;
      wake_n         <= 1'b1;
    end else begin
      defaults_load  <= next_defaults_load;
      miso_oe        <= next_miso_oe;
      cs_accept      <= next_cs_accept;
      frame_abort    <= next_frame_abort;
      supply_state   <= next_supply_state;
      comparators_on <= next_comparators_on;
      current_limit  <= next_current_limit;
      wet_on         <= next_wet_on;
      switch_state   <= next_sw_f;
      int_n          <= next_int_n;
      wake_n         <= next_wake_n;
    end
  end

endmodule
`default_nettype wire

/* File: verif/sstc_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sstc_core_monitor
  import sstc_pkg::*;
(
  // clock, reset, supply and host inputs
  input wire logic                  clock, arst_n, supply_uv, supply_ov, cs_n, sleep_cmd,
  // design outputs
  input wire logic                  miso_oe, cs_accept, frame_abort, comparators_on,
  input wire logic                  current_limit, int_n, wake_n,
  input wire logic [4:0]            supply_state,
  input wire logic [NUM_INPUTS-1:0] wet_on
);
  logic [15:0] fuse_cnt, next_fuse_cnt, low_cnt, next_low_cnt;
  // cycles spent in fuse read, and int_n low time in normal
  always_comb begin
    next_fuse_cnt = (supply_state == 5'h04) ? fuse_cnt + 16'h1 : 16'h0;
    next_low_cnt  = (!int_n && supply_state == 5'h08) ? low_cnt + 16'h1 : 16'h0;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fuse_cnt <= 16'h0;
      low_cnt  <= 16'h0;
    end else begin
      fuse_cnt <= next_fuse_cnt;
      low_cnt  <= next_low_cnt;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_uv_in_frame;
    (supply_uv && !cs_n && supply_state == 5'h08)[*3];
  endsequence
  sequence s_fuse_done;
    supply_state == 5'h04 ##1 supply_state == 5'h08;
  endsequence
  a_lockout_miso_off: assert property (supply_state == 5'h02 |-> !miso_oe)
    else $error("miso enabled in lockout");
  a_cs_outside_normal: assert property (supply_state != 5'h08 |-> !cs_accept)
    else $error("chip select accepted outside normal");
  a_uv_aborts_frame: assert property (s_uv_in_frame |-> ##[0:6] supply_state == 5'h02)
    else $error("undervoltage in frame did not lock out");
  a_lockout_analog_off: assert property (supply_state == 5'h02 |-> !comparators_on && wet_on == '0)
    else $error("analog still on in lockout");
  a_reset_to_lockout: assert property (supply_state == 5'h01 |=> supply_state == 5'h02)
    else $error("reset state not followed by lockout");
  a_fuse_time_window: assert property (s_fuse_done |-> fuse_cnt >= 16'h61a8 && fuse_cnt <= 16'hafc8)
    else $error("start-up time out of window");
  a_wake_in_normal: assert property (supply_state == 5'h08 && $past(supply_state) == 5'h08 |-> !wake_n)
    else $error("wake_n high in normal");
  a_sleep_by_cmd: assert property ($rose(supply_state == 5'h10) |-> $past(sleep_cmd) || $past(sleep_cmd, 2))
    else $error("sleep entered without command");
  a_int_pulse_len: assert property ($rose(int_n) && low_cnt > 16'h64 |-> low_cnt >= 16'h2328 && low_cnt <= 16'h2af8)
    else $error("interrupt pulse length wrong");
  a_ov_limits: assert property ((supply_ov && supply_state == 5'h08)[*6] |-> current_limit)
    else $error("overvoltage not limiting current");
  a_abort_locks_out: assert property (frame_abort |-> supply_state == 5'h02)
    else $error("frame abort outside lockout");
  a_wet_only_normal: assert property (supply_state != 5'h08 |-> wet_on == '0)
    else $error("wetting outside normal");
endmodule
bind sstc_core sstc_core_monitor i_mon (.clock(clock), .arst_n(arst_n), .supply_uv(supply_uv),
  .supply_ov(supply_ov), .cs_n(cs_n), .sleep_cmd(sleep_cmd), .miso_oe(miso_oe),
  .cs_accept(cs_accept), .frame_abort(frame_abort), .comparators_on(comparators_on),
  .current_limit(current_limit), .int_n(int_n), .wake_n(wake_n),
  .supply_state(supply_state), .wet_on(wet_on));
`default_nettype wire

/* File: verif/sstc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sstc_host_model
  import sstc_pkg::*;
(
  input  wire logic clock,
  output logic      cs_n,
  output logic      int_request,
  output logic      sleep_cmd
);
  initial begin
    cs_n        = 1'b1;
    int_request = 1'b0;
    sleep_cmd   = 1'b0;
  end
  task automatic select(input logic on);
    @(posedge clock);
    #1 cs_n = !on;
  endtask
  // level held long enough to pass the input synchroniser
  task automatic req_int();
    @(posedge clock);
    #1 int_request = 1'b1;
    repeat (8) @(posedge clock);
    #1 int_request = 1'b0;
  endtask
  task automatic enter_sleep();
    @(posedge clock);
    #1 sleep_cmd = 1'b1;
    @(posedge clock);
    #1 sleep_cmd = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/supply_state_and_timing_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module supply_state_and_timing_control_bench
  import sstc_pkg::*;
;
  logic clock = 1'b0, arst_n = 1'b0, supply_uv = 1'b1, supply_ov = 1'b0, flags_clear = 1'b0;
  logic cs_n, sleep_cmd, int_request, miso_oe, cs_accept, frame_abort, uv_seen, por_flag;
  logic comparators_on, current_limit, int_n, wake_n;
  logic [4:0] supply_state;
  logic [NUM_INPUTS-1:0] wet_on, switch_state, switch_raw = '0, wet_pulsed_sel = '1;
  logic defaults_load;
  int err_total = 0, n_checks = 0, n;
  always #5 clock = ~clock;
  sstc_host_model host (.clock(clock), .cs_n(cs_n), .int_request(int_request), .sleep_cmd(sleep_cmd));
  sstc_core i_dut (.clock(clock), .arst_n(arst_n), .supply_uv(supply_uv), .supply_ov(supply_ov),
    .cs_n(cs_n), .sleep_cmd(sleep_cmd), .int_request(int_request), .flags_clear(flags_clear),
    .switch_raw(switch_raw), .wet_pulsed_sel(wet_pulsed_sel), .miso_oe(miso_oe),
    .cs_accept(cs_accept), .frame_abort(frame_abort), .supply_state(supply_state),
    .uv_seen(uv_seen), .por_flag(por_flag), .defaults_load(defaults_load),
    .comparators_on(comparators_on), .current_limit(current_limit), .wet_on(wet_on),
    .switch_state(switch_state), .int_n(int_n),
    .wake_n(wake_n));
  task automatic complete_run();
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // which 0: wait for state val; 1: int_n == val[0]; 2: switch_state[1] == val[0]
  task automatic wait_on(input int which, input logic [4:0] val, input int lim, output int c);
    c = 0;
    while ((which == 0 ? supply_state : which == 1 ? {4'h0, int_n} :
            {4'h0, switch_state[1]}) !== val && c < lim) begin
      step(1);
      c++;
    end
    if (c >= lim) begin
      err_total++;
      $display("MISMATCH %0t wait expired", $time);
      complete_run();
    end
  endtask
  initial begin
    wet_pulsed_sel[0] = 1'b0;
    step(8);
    chk(defaults_load === 1'b1 && int_n === 1'b0 && wake_n === 1'b1, "reset outputs");
    arst_n = 1'b1;
    step(3);
    chk(por_flag === 1'b1, "por flag");
    chk(defaults_load === 1'b0, "defaults held");
    chk(supply_state === 5'h02, "not in lockout");
    host.select(1'b1);
    step(10);
    chk(cs_accept === 1'b0 && miso_oe === 1'b0, "cs taken in lockout");
    host.select(1'b0);
    supply_uv = 1'b0;
    wait_on(0, 5'h04, 20, n);
    wait_on(0, 5'h08, 46000, n);
    chk(n >= 25000 && n <= 45000, "start-up time");
    step(2);
    chk(wake_n === 1'b0 && int_n === 1'b1, "normal pins");
    chk(wet_on[0] === 1'b1 && wet_on[1] === 1'b0, "wetting forms");
    flags_clear = 1'b1;
    step(1);
    flags_clear = 1'b0;
    step(1);
    chk(por_flag === 1'b0, "por flag clear");
    host.req_int();
    wait_on(1, 5'h00, 40, n);
    wait_on(1, 5'h01, 12000, n);
    chk(n >= 8995 && n <= 11000, "int pulse length");
    host.select(1'b1);
    step(10);
    chk(cs_accept === 1'b1 && miso_oe === 1'b1, "frame refused");
    supply_uv = 1'b1;
    step(10);
    chk(frame_abort === 1'b1 && supply_state === 5'h02, "frame not aborted");
    chk(miso_oe === 1'b0 && comparators_on === 1'b0 && wet_on === '0, "lockout outputs");
    host.select(1'b0);
    supply_uv = 1'b0;
    wait_on(0, 5'h08, 46000, n);
    chk(uv_seen === 1'b1, "uv status");
    supply_ov = 1'b1;
    step(10);
    chk(current_limit === 1'b1 && supply_state === 5'h08, "ov limit");
    supply_ov = 1'b0;
    step(10);
    chk(current_limit === 1'b0, "ov restore");
    // 2 us glitch, well under the shortest filter time
    switch_raw[2] = 1'b1;
    step(200);
    switch_raw[2] = 1'b0;
    step(100);
    chk(switch_state[2] === 1'b0 && int_n === 1'b1, "glitch passed");
    switch_raw[1] = 1'b1;
    wait_on(2, 5'h01, 2000, n);
    chk(n >= 500 && n <= 1800 && int_n === 1'b0, "filter time");
    step(3);
    chk(wet_on[1] === 1'b1, "pulse wetting");
    host.enter_sleep();
    step(3);
    chk(supply_state === 5'h10, "sleep entry");
    chk(wet_on === '0 && comparators_on === 1'b1 && wake_n === 1'b1, "sleep outputs");
    arst_n = 1'b0;
    step(2);
    chk(supply_state === 5'h01 && defaults_load === 1'b1 && int_n === 1'b0, "mid reset");
    arst_n = 1'b1;
    step(3);
    chk(supply_state === 5'h02 && por_flag === 1'b1 && defaults_load === 1'b0, "restart");
    complete_run();
  end
endmodule
`default_nettype wire
